/* File: design/nvs_pkg.sv */
// constants, opcodes and status layout for the serial nvram slave port
// What this block does
// - deselected: standby, serial output undriven
// - deselected: clock, data, protect inputs ignored
// - select low enters active, accepts input
// - status writes gated by protect pin, lock
// - reset low returns interface to idle
// - serial input sampled on clock rise
// - serial output changes on clock fall
// - array and status read out serially
// - modes zero and three both supported
// - slave only; host makes clock, select
// - main array 524288 bytes, 19-bit address
// - 256-byte special sector, 64-bit serial number
// - 8-bit opcode; early deselect discards command
// - writes need latch; set/clear commands
// - latch cleared at reset; writes keep it
package nvs_pkg;
  // opcodes
  localparam logic [7:0] OP_SET_WEL  = 8'h06;
  localparam logic [7:0] OP_CLR_WEL  = 8'h04;
  localparam logic [7:0] OP_RD_STAT  = 8'h05;
  localparam logic [7:0] OP_WR_STAT  = 8'h01;
  localparam logic [7:0] OP_RD_MEM   = 8'h03;
  localparam logic [7:0] OP_WR_MEM   = 8'h02;
  localparam logic [7:0] OP_FRD_MEM  = 8'h0b;
  localparam logic [7:0] OP_WR_SN    = 8'hc2;
  localparam logic [7:0] OP_RD_SN    = 8'hc3;
  localparam logic [7:0] OP_WR_SS    = 8'h42;
  localparam logic [7:0] OP_RD_SS    = 8'h4b;
  localparam logic [7:0] OP_FRD_SS   = 8'h49;
  // memory geometry
  localparam int         MAIN_DEPTH  = 524288;
  localparam int         SS_DEPTH    = 256;
  localparam int         SN_BYTES    = 8;
  localparam int         PHYS_AW     = 20;
  localparam int         MEM_DEPTH   = MAIN_DEPTH + SS_DEPTH + SN_BYTES;
  localparam logic [19:0] SS_BASE    = 20'h80000;
  localparam logic [19:0] SN_BASE    = 20'h80100;
  localparam logic [1:0] ADDR_LAST   = 2'h2;
  // status layout: bits 7..2 stored, bit 1 latch, bit 0 zero
  localparam int         STAT_LOCK_BIT = 7;
  localparam logic [5:0] STAT_RST    = 6'h00;
  // address region of the current command
  typedef enum logic [1:0] {RG_MAIN, RG_SS, RG_SN} nvs_region_t;
endpackage

/* File: design/nvs_mem_if.sv */
// memory port between the serial front end and its byte store
`timescale 1ns/1ps
`default_nettype none
interface nvs_mem_if #(parameter int AW = 20);
  logic [AW-1:0] addr;   // byte address
  logic [7:0]    wdata;  // write byte
  logic          we;     // write strobe
  logic          re;     // read strobe
  logic [7:0]    rdata;  // registered read byte
  modport ctl (output addr, output wdata, output we, output re, input rdata);
  modport mem (input addr, input wdata, input we, input re, output rdata);
endinterface
`default_nettype wire

/* File: design/nvs_sync.sv */
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module nvs_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  // pins in, filtered levels out
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] stable_o
);
  logic [W-1:0] s1_r;  // metastable stage, read only by s2
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // shift chain; output moves only when stages two and three agree
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_r     <= RST_VAL;
      s2_r     <= RST_VAL;
      s3_r     <= RST_VAL;
      stable_o <= RST_VAL;
    end else begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          stable_o[i] <= s3_r[i];
        end
      end
    end
  end
endmodule // nvs_sync
`default_nettype wire

/* File: design/nvs_mem.sv */
// byte store for main array, special sector and serial number
`timescale 1ns/1ps
`default_nettype none
module nvs_mem #(
  parameter int DEPTH = nvs_pkg::MEM_DEPTH
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // access port
  nvs_mem_if.mem    mp
);
  logic [7:0] store [DEPTH];  // no reset: contents are nonvolatile

  // write port
  always_ff @(posedge core_clk) begin
    if (mp.we) begin
      store[mp.addr] <= mp.wdata;
    end
  end

  // registered read port
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mp.rdata <= 8'h00;
    end else if (mp.re) begin
      mp.rdata <= store[mp.addr];
    end
  end
endmodule // nvs_mem
`default_nettype wire

/* File: design/nvs_port.sv */
// serial slave front end of the byte-wide nonvolatile memory
`timescale 1ns/1ps
`default_nettype none
module nvs_port (
  // clock and reset (reset pin of the device)
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // serial link pins from the host
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic       si,
  input  wire logic       wp_n,
  output logic            so,
  output logic            so_oe,
  // command and status view for the rest of the device
  output logic [7:0]      cmd_opcode,
  output logic            cmd_valid,
  output logic            write_enable_latch,
  output logic            status_lock_enable,
  output logic            selected
);
  import nvs_pkg::*;

  typedef enum {ST_IDLE, ST_OPC, ST_ADDR, ST_DUMMY, ST_RDATA, ST_WDATA,
                ST_STAT_RD, ST_STAT_WR, ST_IGNORE} nvs_state_t;

  // synchronised pins
  logic        cs_s;      // select, high = deselected
  logic        sck_s;     // serial clock level
  logic        si_s;      // serial data in
  logic        wp_s;      // protect pin, low = protect
  logic        sck_d_r;   // previous clock level
  logic        rise;      // clock rising edge seen
  logic        fall;      // clock falling edge seen
  // serial engine
  nvs_state_t  state_r;
  nvs_state_t  state_nxt;
  logic [2:0]  bit_cnt_r;   // bits taken in current byte
  logic [6:0]  rx_r;        // partial byte
  logic        byte_done;   // eighth bit sampled this cycle
  logic [7:0]  byte_val;    // completed byte
  logic        rose_r;      // a rising edge seen since select
  logic [7:0]  op_r;        // opcode of current command
  logic [1:0]  abyte_r;     // address byte index
  logic [23:0] addr_r;      // byte address within region
  nvs_region_t region_r;
  logic [7:0]  tx_r;        // output shifter, msb on the pin
  logic        load;        // new output byte needed
  logic        rd_req_r;    // memory read strobe
  logic [5:0]  stat_r;      // stored status bits 7..2
  logic        wel_r;       // write enable latch
  logic        locked;      // status write blocked
  logic [7:0]  stat_byte;
  logic        so_oe_r;

  nvs_mem_if #(.AW(PHYS_AW)) mif ();

  // address within the physical store
  function automatic logic [19:0] phys(input nvs_region_t rg, input logic [23:0] a);
    unique case (rg)
      RG_SS:   phys = SS_BASE | {12'h000, a[7:0]};
      RG_SN:   phys = SN_BASE | {17'h00000, a[2:0]};
      default: phys = {1'b0, a[18:0]};
    endcase
  endfunction

  // opcodes that write the store
  function automatic logic is_write(input logic [7:0] op);
    is_write = (op == OP_WR_MEM) || (op == OP_WR_SS) || (op == OP_WR_SN);
  endfunction

  // pin synchroniser; select and clock rest high
  nvs_sync #(.W(4), .RST_VAL(4'hb)) u_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .async_i  ({cs_n, wp_n, si, sck}),
    .stable_o ({cs_s, wp_s, si_s, sck_s})
  );

  // byte store
  nvs_mem #(.DEPTH(MEM_DEPTH)) u_mem (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .mp       (mif.mem)
  );

  // edge finder; edges count only while selected
  // resets to the synchroniser's clock level so no false edge follows reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_d_r <= 1'b1;
    end else begin
      sck_d_r <= sck_s;
    end
  end
  assign rise      = !cs_s && sck_s && !sck_d_r;
  assign fall      = !cs_s && !sck_s && sck_d_r;
  assign byte_done = rise && (bit_cnt_r == 3'h7);
  assign byte_val  = {rx_r, si_s};

  // receive shifter, msb first
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt_r <= 3'h0;
      rx_r      <= 7'h00;
      rose_r    <= 1'b0;
    end else if (cs_s) begin
      bit_cnt_r <= 3'h0;  // partial opcode dropped on deselect
      rose_r    <= 1'b0;
    end else if (rise) begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      rx_r      <= byte_val[6:0];
      rose_r    <= 1'b1;
    end
  end

  // next state; idle moves to opcode phase at once, the rest on each completed byte
  always_comb begin
    state_nxt = state_r;
    if (state_r == ST_IDLE) begin
      state_nxt = ST_OPC;
    end else if (byte_done) begin
      unique case (state_r)
        ST_OPC: begin
          unique case (byte_val)
            OP_RD_STAT: state_nxt = ST_STAT_RD;
            OP_WR_STAT: state_nxt = ST_STAT_WR;
            OP_RD_MEM, OP_WR_MEM, OP_FRD_MEM,
            OP_WR_SS, OP_RD_SS, OP_FRD_SS: state_nxt = ST_ADDR;
            OP_WR_SN: state_nxt = ST_WDATA;
            OP_RD_SN: state_nxt = ST_RDATA;
            default:  state_nxt = ST_IGNORE;
          endcase
        end
        ST_ADDR: begin
          if (abyte_r == ADDR_LAST) begin
            if (is_write(op_r)) begin
              state_nxt = ST_WDATA;
            end else if (op_r == OP_FRD_MEM || op_r == OP_FRD_SS) begin
              state_nxt = ST_DUMMY;
            end else begin
              state_nxt = ST_RDATA;
            end
          end
        end
        ST_DUMMY:   state_nxt = ST_RDATA;
        ST_STAT_WR: state_nxt = ST_IGNORE;
        default:    state_nxt = state_r;  // read, write and ignore stay
      endcase
    end
  end

  // state register; deselect always wins
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
    end else if (cs_s) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // opcode capture and command strobe, only after all eight bits
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      op_r      <= 8'h00;
      cmd_valid <= 1'b0;
    end else begin
      cmd_valid <= byte_done && (state_r == ST_OPC);
      if (byte_done && state_r == ST_OPC) begin
        op_r <= byte_val;
      end
    end
  end
  assign cmd_opcode = op_r;

  // address collection and stepping
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      abyte_r  <= 2'h0;
      addr_r   <= 24'h000000;
      region_r <= RG_MAIN;
    end else if (byte_done && state_r == ST_OPC) begin
      abyte_r  <= 2'h0;
      addr_r   <= 24'h000000;  // serial number starts at byte zero
      if (byte_val == OP_WR_SN || byte_val == OP_RD_SN) begin
        region_r <= RG_SN;
      end else if (byte_val == OP_WR_SS || byte_val == OP_RD_SS || byte_val == OP_FRD_SS) begin
        region_r <= RG_SS;
      end else begin
        region_r <= RG_MAIN;
      end
    end else if (byte_done && state_r == ST_ADDR) begin
      abyte_r <= abyte_r + 2'h1;
      addr_r  <= {addr_r[15:0], byte_val};
    end else if ((byte_done && state_r == ST_WDATA) || (load && state_r == ST_RDATA)) begin
      addr_r <= addr_r + 24'h000001;  // sequential access
    end
  end

  // memory access; writes only with latch set
  assign mif.addr  = phys(region_r, addr_r);
  assign mif.wdata = byte_val;
  assign mif.we    = byte_done && (state_r == ST_WDATA) && wel_r;
  assign mif.re    = rd_req_r;

  // read strobe on entry to read-out and after each byte handed over
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_req_r <= 1'b0;
    end else begin
      rd_req_r <= (!cs_s && state_r != ST_RDATA && state_nxt == ST_RDATA) ||
                  (load && state_r == ST_RDATA);
    end
  end

  // write enable latch
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wel_r <= 1'b0;
    end else if (byte_done && state_r == ST_OPC) begin
      if (byte_val == OP_SET_WEL) begin
        wel_r <= 1'b1;
      end else if (byte_val == OP_CLR_WEL) begin
        wel_r <= 1'b0;
      end
    end
  end

  // status bits; locked while lock bit set and protect pin low
  assign locked = stat_r[STAT_LOCK_BIT-2] && !wp_s;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stat_r <= STAT_RST;
    end else if (byte_done && state_r == ST_STAT_WR && wel_r && !locked) begin
      stat_r <= byte_val[7:2];
    end
  end
  assign stat_byte          = {stat_r, wel_r, 1'b0};
  assign write_enable_latch = wel_r;
  assign status_lock_enable = stat_r[STAT_LOCK_BIT-2];
  assign selected           = !cs_s;

  // output shifter; mode three's leading fall is skipped via rose_r
  assign load = fall && rose_r && (bit_cnt_r == 3'h0);
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_r <= 8'h00;
    end else if (load) begin
      tx_r <= (state_r == ST_STAT_RD) ? stat_byte : mif.rdata;
    end else if (fall && rose_r) begin
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end
  assign so = tx_r[7];

  // drive the pin only in read-out phases so a shared line stays free
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      so_oe_r <= 1'b0;
    end else begin
      so_oe_r <= !cs_s && (state_r == ST_RDATA || state_r == ST_STAT_RD);
    end
  end
  assign so_oe = so_oe_r && !cs_s;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence s_set_cmd;
    cmd_valid && cmd_opcode == OP_SET_WEL;
  endsequence
  sequence s_clr_cmd;
    cmd_valid && cmd_opcode == OP_CLR_WEL;
  endsequence
  sequence s_stat_write;
    byte_done && state_r == ST_STAT_WR;
  endsequence

  chk_desel_hiz: assert property (cs_s |-> !so_oe)
    else $error("output driven while deselected");
  chk_desel_idle: assert property (cs_s |=> state_r == ST_IDLE && bit_cnt_r == 3'h0)
    else $error("engine active while deselected");
  chk_select_active: assert property ($fell(cs_s) ##1 !cs_s |-> state_r == ST_OPC)
    else $error("select did not start opcode phase");
  chk_rise_sample: assert property (rise && bit_cnt_r != 3'h7 |=> rx_r[0] == $past(si_s))
    else $error("input not sampled on rising edge");
  chk_fall_shift: assert property (!cs_s && $changed(tx_r) |-> $past(fall))
    else $error("output moved without falling edge");
  chk_latch_set: assert property (s_set_cmd |-> wel_r)
    else $error("latch not set by set command");
  chk_latch_clear: assert property (s_clr_cmd |-> !wel_r)
    else $error("latch not cleared by clear command");
  chk_status_lock: assert property (s_stat_write ##0 (locked || !wel_r) |=> $stable(stat_r))
    else $error("protected status was written");
  chk_opcode_full: assert property (cmd_valid |-> $past(state_r) == ST_OPC && $past(bit_cnt_r) == 3'h7)
    else $error("command without eight opcode bits");
  chk_write_keep: assert property (mif.we |=> wel_r)
    else $error("write dropped the latch");
endmodule // nvs_port
`default_nettype wire

/* File: test/nvs_host.sv */
// host serial master model that drives the port's select, clock and data pins
`timescale 1ns/1ps
`default_nettype none
module nvs_host (
  // clock
  input  wire logic core_clk,
  // serial pins
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  input  wire logic so
);
  localparam int HALF = 6; // sck half period in core_clk cycles, 48 ns period
  logic          mode3;    // clock idles high

  // pins parked deselected from time zero
  initial begin
    cs_n  = 1'b1;
    sck   = 1'b0;
    si    = 1'b0;
    mode3 = 1'b0;
  end

  // all pin changes land on falling core_clk edges
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // park the clock at its idle level while deselected, then select
  task automatic start(input logic m3);
    mode3 = m3;
    tick(1);
    sck = m3;
    tick(10);
    cs_n = 1'b0;
    tick(10);
  endtask

  // one bit each way; the read bit is taken at the rising clock edge
  task automatic bit_x(input logic b, output logic r);
    if (mode3) begin
      sck = 1'b0; // mode three leads with a fall
    end
    si = b;
    tick(HALF);
    sck = 1'b1;
    r = so;
    tick(HALF);
    if (!mode3) begin
      sck = 1'b0;
    end
  endtask

  // whole byte, msb first both ways
  task automatic byte_x(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
  endtask

  // only the top n bits, for a command cut short
  task automatic bits_x(input logic [7:0] tx, input int n);
    logic r;
    for (int i = 7; i > 7 - n; i--) bit_x(tx[i], r);
  endtask

  // deselect; data line left showing something other than its last bit
  task automatic stop();
    tick(2);
    cs_n = 1'b1;
    si = ~si;
    tick(10);
  endtask

  // clock and data wiggle while deselected; clock ends at its start level
  task automatic noise();
    for (int i = 0; i < 16; i++) begin
      sck = ~sck;
      si = ~si;
      tick(3);
    end
  endtask
endmodule // nvs_host
`default_nettype wire

/* File: test/test_nvs_port.sv */
// self-checking bench for the serial nvram slave port
`timescale 1ns/1ps
`default_nettype none
module test_nvs_port;
  import nvs_pkg::*;
  logic       core_clk;           // 250 MHz system clock
  logic       reset_n;            // device reset pin
  logic       wp_n;               // write-protect pin
  wire        cs_n;               // from host model
  wire        sck;                // from host model
  wire        si;                 // from host model
  logic       so;                 // serial out
  logic       so_oe;              // serial out enable
  logic [7:0] cmd_opcode;         // last opcode
  logic       cmd_valid;          // opcode pulse
  logic       write_enable_latch; // latch view
  logic       status_lock_enable; // lock view
  logic       selected;           // select view
  logic [15:0] r;                 // read-back bytes
  int         err_count = 0;
  int         n_tests = 0;
  int         n_cmd = 0;          // opcode pulses seen
  int         exp_cmd = 0;        // opcode pulses expected
  // undriven line toggles with the clock, so a missing enable corrupts data
  wire so_line = so_oe ? so : ~sck;

  nvs_port i_nvs_port (.core_clk(core_clk), .reset_n(reset_n), .cs_n(cs_n), .sck(sck), .si(si),
    .wp_n(wp_n), .so(so), .so_oe(so_oe), .cmd_opcode(cmd_opcode), .cmd_valid(cmd_valid),
    .write_enable_latch(write_enable_latch), .status_lock_enable(status_lock_enable),
    .selected(selected));
  nvs_host i_nvs_host (.core_clk(core_clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so_line));

  // clock, 4 ns period
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // count one-cycle opcode pulses
  always @(posedge core_clk) begin
    if (cmd_valid === 1'b1) n_cmd <= n_cmd + 1;
  end

  // compare and report
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic test_done();
    $display("errors %0d comparisons %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // one full frame: opcode, na address or dummy bytes, nd data bytes
  task automatic frame(input logic m3, input logic [7:0] op, input int na, input logic [31:0] a,
                       input int nd, input logic [15:0] d, output logic [15:0] rd);
    logic [7:0] junk;
    rd = 16'h0000;
    i_nvs_host.start(m3);
    check(selected, 1'b1);
    i_nvs_host.byte_x(op, junk);
    if (na > 0) check(so_oe, 1'b0);
    for (int i = 0; i < na; i++) i_nvs_host.byte_x(a[31-8*i -: 8], junk);
    for (int i = 0; i < nd; i++) i_nvs_host.byte_x(d[15-8*i -: 8], rd[15-8*i -: 8]);
    i_nvs_host.stop();
    exp_cmd++;
    check({so_oe, selected}, 2'b00);
    check(cmd_opcode, op);
  endtask

  // hang guard
  initial begin
    #200000;
    err_count++;
    test_done();
  end

  // main sequence
  initial begin
    reset_n = 1'b0;
    wp_n = 1'b1;
    repeat (20) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (2) @(negedge core_clk);
    check({so_oe, write_enable_latch, status_lock_enable, selected, cmd_opcode}, 12'h000);
    i_nvs_host.noise();
    check({n_cmd[3:0], selected, write_enable_latch}, 6'h00);
    frame(0, OP_SET_WEL, 0, 0, 0, 0, r);
    check(write_enable_latch, 1'b1);
    frame(0, OP_RD_STAT, 0, 0, 2, 0, r);
    check(r, 16'h0202);
    frame(1, OP_RD_STAT, 0, 0, 1, 0, r);
    check(r, 16'h0200);
    frame(1, OP_WR_MEM, 3, {24'h07fffe, 8'h00}, 2, 16'ha55c, r);
    check(write_enable_latch, 1'b1);
    frame(0, OP_RD_MEM, 3, {24'h07fffe, 8'h00}, 2, 0, r);
    check(r, 16'ha55c);
    frame(1, OP_FRD_MEM, 4, {24'hf7fffe, 8'hff}, 2, 0, r);
    check(r, 16'ha55c);
    frame(0, OP_WR_SS, 3, {24'h0000ff, 8'h00}, 1, 16'h3c00, r);
    frame(0, OP_RD_SS, 3, {24'h0000ff, 8'h00}, 1, 0, r);
    check(r, 16'h3c00);
    frame(1, OP_FRD_SS, 4, {24'h0000ff, 8'h00}, 1, 0, r);
    check(r, 16'h3c00);
    frame(0, OP_WR_SN, 0, 0, 2, 16'h1234, r);
    frame(1, OP_RD_SN, 0, 0, 2, 0, r);
    check(r, 16'h1234);
    i_nvs_host.start(0);
    i_nvs_host.bits_x(OP_CLR_WEL, 7);
    i_nvs_host.stop();
    check({write_enable_latch, n_cmd[7:0]}, {1'b1, exp_cmd[7:0]});
    // unknown opcode: the following clear-latch byte must not be decoded
    frame(0, 8'h00, 0, 0, 1, 16'h0400, r);
    check(write_enable_latch, 1'b1);
    frame(0, OP_CLR_WEL, 0, 0, 0, 0, r);
    check(write_enable_latch, 1'b0);
    frame(0, OP_WR_MEM, 3, {24'h07fffe, 8'h00}, 1, 16'h0000, r);
    frame(0, OP_RD_MEM, 3, {24'h07fffe, 8'h00}, 1, 0, r);
    check(r, 16'ha500);
    frame(0, OP_SET_WEL, 0, 0, 0, 0, r);
    frame(0, OP_WR_STAT, 0, 0, 1, 16'h8000, r);
    check({status_lock_enable, write_enable_latch}, 2'b11);
    wp_n = 1'b0;
    frame(1, OP_WR_STAT, 0, 0, 1, 16'h0000, r);
    check(status_lock_enable, 1'b1);
    frame(1, OP_RD_STAT, 0, 0, 1, 0, r);
    check(r, 16'h8200);
    wp_n = 1'b1;
    frame(0, OP_WR_STAT, 0, 0, 1, 16'h0000, r);
    check(status_lock_enable, 1'b0);
    reset_n = 1'b0;
    repeat (4) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (2) @(negedge core_clk);
    check({write_enable_latch, selected, so_oe}, 3'h0);
    frame(0, OP_RD_STAT, 0, 0, 1, 0, r);
    check(r, 16'h0000);
    check(n_cmd[15:0], exp_cmd[15:0]);
    test_done();
  end
endmodule // test_nvs_port
`default_nettype wire
